// ---- bench/dcrb_far_model.sv ----
// Purpose: Far-side model, downstream sink and board straps
// Assumes: Runs on the buffer clock
// Notes: Slow mode takes a word every other cycle
`timescale 1ns/1ns
module dcrb_far_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic slow,
	output logic drive_ready,
	output logic strap_tie_low,
	output logic strap_tie_high
);
	logic phase_reg;
	assign strap_tie_low = 1'h0;
	assign strap_tie_high = 1'h1;
	assign drive_ready = !stall && (!slow || phase_reg);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) phase_reg <= 1'h0;
		else phase_reg <= !phase_reg;
	end
endmodule : dcrb_far_model

// ---- bench/ddr2_command_register_buffer_test.sv ----
// Purpose: Self-checking bench of the command register buffer
// Assumes: Inputs change on the falling edge
// Notes: Monitor tracks the last captured word
`timescale 1ns/1ns
module ddr2_command_register_buffer_test;
	import dcrb_pkg::*;
	localparam int W = 22;
	logic clock = 0, rst_n = 1, clk_en = 1, gate = 0, stall = 0, slow = 0, pbit = 0;
	logic [3:0] sel_n = 4'hF;
	logic [W-1:0] din = '0, last_word = '0, w;
	logic g1 = 0, gs = 0, saw_full = 0;
	wire drive_ready, tie_lo, tie_hi, cmd_ready, fault_n, fault_oe, strap_ok;
	wire [W-1:0] qa, qb;
	dcrb_pf_state_t fstate;
	int mismatches = 0, checks_done = 0, cycles = 0, seed = 32'hE6779B32;
	dcrb_far_model i_far (.clock(clock), .rst_n(rst_n), .stall(stall), .slow(slow),
		.drive_ready(drive_ready), .strap_tie_low(tie_lo), .strap_tie_high(tie_hi));
	dcrb_buffer i_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .select_gate_enable(gate),
		.chip_select_in_0(sel_n[0]), .chip_select_in_1(sel_n[1]), .chip_select_in_2(sel_n[2]),
		.chip_select_in_3(sel_n[3]), .cmd_addr_inputs(din), .cmd_ready(cmd_ready),
		.drive_ready(drive_ready), .cmd_addr_outputs_copy_a(qa), .cmd_addr_outputs_copy_b(qb),
		.parity_bit_in(pbit), .parity_fault_n(fault_n), .parity_fault_oe(fault_oe),
		.strap_tie_low(tie_lo), .strap_tie_high(tie_hi), .strap_ok(strap_ok), .fault_state(fstate));
	initial forever #50 clock = ~clock;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			g1 = 0;
			gs = 0;
			last_word = '0;
		end else if (clk_en) begin
			if (cmd_ready && (!gs || !(&sel_n))) last_word = din;
			if (!cmd_ready) saw_full = 1;
			gs = g1;
			g1 = gate;
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end
	function automatic logic fault_exp(input logic [W-1:0] word, input logic pb);
		return ^word ^ pb;
	endfunction : fault_exp
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic drain();
		gate = 1;
		sel_n = 4'hF;
		stall = 0;
		clk_en = 1;
		repeat (30) begin
			@(negedge clock);
			din = $random(seed);
		end
		check(qa, last_word);
		check(qb, last_word);
	endtask : drain
	task automatic parity_case(input logic odd, input logic pb, input int k, input logic cut);
		logic bad;
		@(negedge clock);
		w = $random(seed);
		if (^w != odd) w[0] = !w[0];
		bad = fault_exp(w, pb);
		din = w;
		sel_n = 4'hF ^ (4'h1 << k);
		@(negedge clock);
		sel_n = 4'hF;
		pbit = pb;
		@(negedge clock);
		pbit = 0;
		check(fstate, bad ? DCRB_PF_WAIT : DCRB_PF_IDLE);
		repeat (2) begin
			@(negedge clock);
			check(fault_n, !bad);
			check(fault_oe, bad);
			if (cut) begin
				rst_n = 0;
				#1;
				check(fault_n, 1'h1);
				check(fault_oe, 1'h0);
				check(qa, '0);
				repeat (6) @(negedge clock);
				rst_n = 1;
				return;
			end
		end
		@(negedge clock);
		check(fault_n, 1'h1);
	endtask : parity_case
	initial begin
		#1 rst_n = 0;
		repeat (6) @(negedge clock);
		check(qa, '0);
		check(fault_n, 1'h1);
		rst_n = 1;
		repeat (4) @(negedge clock);
		check(strap_ok, 1'h1);
		repeat (8) begin
			gate = $random(seed);
			slow = $random(seed);
			repeat (16) begin
				@(negedge clock);
				din = $random(seed);
				sel_n = $random(seed) | $random(seed);
				clk_en = ($random(seed) & 7) != 0;
				pbit = $random(seed);
			end
			drain();
		end
		repeat (10) begin
			@(negedge clock);
			din = $random(seed);
			check(qa, last_word);
		end
		for (int i = 0; i < 8; i++) parity_case(i[0], i[1] ^ i[2], i % 4, 0);
		stall = 1;
		gate = 0;
		slow = 0;
		saw_full = 0;
		repeat (14) begin
			@(negedge clock);
			din = $random(seed);
		end
		check(saw_full, 1'h1);
		drain();
		parity_case(1, 0, 0, 1);
		@(negedge clock);
		check(qa, '0);
		check(fstate, DCRB_PF_IDLE);
		drain();
		final_report();
	end
endmodule : ddr2_command_register_buffer_test

// ---- core/dcrb_buffer.sv ----
// Purpose: Registered address/command buffer with parity checking
// Assumes: Command, select and parity inputs come from logic on clock
// Notes: Gate enable and straps are static pins and are synchronised
// Overview of operation
// - Gate high: capture only with a select low
// - Gate low: capture on every rising edge with clock enable high and FIFO room
// - Only rising clock edges and the asynchronous reset update state
// - Reset clears state, drives both command output copies low asynchronously
// - Reset clears the parity fault output
// - Parity bit follows its word by one cycle
// - Mismatch: fault low two cycles, one delayed
// - Extra selects gate capture, have no outputs
`timescale 1ns/1ns
`include "dcrb_defs.svh"
module dcrb_buffer #(
	parameter int WIDTH = `DCRB_CMD_WIDTH,
	parameter int DEPTH = `DCRB_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic select_gate_enable,
	input wire logic chip_select_in_0,
	input wire logic chip_select_in_1,
	input wire logic chip_select_in_2,
	input wire logic chip_select_in_3,
	input wire logic [WIDTH-1:0] cmd_addr_inputs,
	output logic cmd_ready,
	input wire logic drive_ready,
	output logic [WIDTH-1:0] cmd_addr_outputs_copy_a,
	output logic [WIDTH-1:0] cmd_addr_outputs_copy_b,
	input wire logic parity_bit_in,
	output logic parity_fault_n,
	output logic parity_fault_oe,
	input wire logic strap_tie_low,
	input wire logic strap_tie_high,
	output logic strap_ok,
	output dcrb_pkg::dcrb_pf_state_t fault_state
);
	import dcrb_pkg::*;
	localparam int FCW = `DCRB_FAULT_CNT_W;
	localparam int FAULT_CYCLES = `DCRB_FAULT_CYCLES;
	if (WIDTH < 1 || FAULT_CYCLES < 1 || FAULT_CYCLES > (1 << FCW)) begin : g_bad_param
		$error("dcrb_buffer: width or fault length out of range");
	end
	typedef struct packed {
		logic gate_meta;
		logic gate_sync;
		logic [1:0] strap_meta;
		logic [1:0] strap_sync;
		logic chk_pend;
		logic word_par;
		dcrb_pf_state_t pf_state;
		logic [FCW-1:0] pf_cnt;
		logic fault_n;
		logic [WIDTH-1:0] out_a;
		logic [WIDTH-1:0] out_b;
	} dcrb_top_state_t;
	localparam dcrb_top_state_t S_RESET = '{
		pf_state: DCRB_PF_IDLE,
		fault_n: `DCRB_FAULT_IDLE_N,
		default: '0
	};
	function automatic logic select_active(input logic cs0, input logic cs1, input logic cs2, input logic cs3);
		select_active = !(cs0 && cs1 && cs2 && cs3);
	endfunction : select_active
	function automatic logic word_parity(input logic [WIDTH-1:0] w);
		word_parity = ^w;
	endfunction : word_parity
	dcrb_top_state_t s_reg;
	dcrb_top_state_t s_next;
	logic any_select;
	logic capture;
	logic mismatch;
	logic fifo_valid;
	logic [WIDTH-1:0] fifo_data;
	logic drive_pop;
	// Any of the four selects low opens the gate
	assign any_select = select_active(chip_select_in_0, chip_select_in_1, chip_select_in_2, chip_select_in_3);
	// Gate enable high limits capture to selected cycles
	assign capture = any_select || !s_reg.gate_sync;
	assign mismatch = s_reg.chk_pend && (s_reg.word_par ^ parity_bit_in);
	assign drive_pop = fifo_valid && drive_ready && clk_en;
	dcrb_fifo #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.in_valid(capture),
		.in_ready(cmd_ready),
		.in_data(cmd_addr_inputs),
		.out_valid(fifo_valid),
		.out_ready(drive_ready),
		.out_data(fifo_data)
	);
	always_comb begin
		s_next = s_reg;
		if (clk_en) begin
			s_next.gate_meta = select_gate_enable;
			s_next.gate_sync = s_reg.gate_meta;
			s_next.strap_meta = {strap_tie_high, strap_tie_low};
			s_next.strap_sync = s_reg.strap_meta;
			// Word parity is held one cycle for the late parity bit
			s_next.chk_pend = any_select;
			s_next.word_par = word_parity(cmd_addr_inputs);
			// Outputs move only when a captured word is drained
			if (drive_pop) begin
				s_next.out_a = fifo_data;
				s_next.out_b = fifo_data;
			end
			case (s_reg.pf_state)
				DCRB_PF_IDLE: begin
					if (mismatch) begin
						s_next.pf_state = DCRB_PF_WAIT;
					end
				end
				DCRB_PF_WAIT: begin
					// Extra cycle of delay before the fault shows
					s_next.pf_state = DCRB_PF_LOW;
					s_next.pf_cnt = FCW'(FAULT_CYCLES - 1);
				end
				DCRB_PF_LOW: begin
					if (mismatch) begin
						s_next.pf_cnt = FCW'(FAULT_CYCLES - 1);
					end else if (s_reg.pf_cnt == '0) begin
						s_next.pf_state = DCRB_PF_IDLE;
					end else begin
						s_next.pf_cnt = s_reg.pf_cnt - 1'b1;
					end
				end
				default: begin
					s_next.pf_state = DCRB_PF_IDLE;
					s_next.pf_cnt = '0;
				end
			endcase
			s_next.fault_n = (s_next.pf_state != DCRB_PF_LOW);
		end
	end
	// Single rising-edge process with asynchronous clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= S_RESET;
		end else begin
			s_reg <= s_next;
		end
	end
	assign cmd_addr_outputs_copy_a = s_reg.out_a;
	assign cmd_addr_outputs_copy_b = s_reg.out_b;
	assign parity_fault_n = s_reg.fault_n;
	assign parity_fault_oe = !s_reg.fault_n;
	assign fault_state = s_reg.pf_state;
	// Board is expected to hold the straps at fixed levels
	assign strap_ok = (s_reg.strap_sync[0] == `DCRB_STRAP_LOW_OK) && (s_reg.strap_sync[1] == `DCRB_STRAP_HIGH_OK);
	sequence s_mismatch;
		mismatch && clk_en;
	endsequence
	sequence s_fault_fall;
		$fell(parity_fault_n);
	endsequence
	sequence s_gated_idle;
		s_reg.gate_sync && !any_select && clk_en;
	endsequence
	sequence s_quiet;
		clk_en && !mismatch;
	endsequence
	a_gate_capture: assert property (@(posedge clock) disable iff (!rst_n)
		s_gated_idle |-> !capture) else $error("capture while gated and unselected");
	a_open_capture: assert property (@(posedge clock) disable iff (!rst_n)
		(!s_reg.gate_sync && clk_en) |-> capture) else $error("no capture with gate low");
	a_extra_select: assert property (@(posedge clock) disable iff (!rst_n)
		(s_reg.gate_sync && !chip_select_in_3 && clk_en) |-> capture) else $error("select three ignored");
	a_edge_only: assert property (@(posedge clock) disable iff (!rst_n)
		$changed(cmd_addr_outputs_copy_a) |-> $past(clk_en)) else $error("output moved while frozen");
	a_reset_low: assert property (@(posedge clock)
		!rst_n |-> (cmd_addr_outputs_copy_a == '0 && cmd_addr_outputs_copy_b == '0)) else $error("outputs not low in reset");
	a_reset_fault: assert property (@(posedge clock)
		!rst_n |-> (parity_fault_n && !parity_fault_oe)) else $error("fault active in reset");
	a_parity_delay: assert property (@(posedge clock) disable iff (!rst_n)
		(s_mismatch and (fault_state == DCRB_PF_IDLE)) ##1 clk_en |=> !parity_fault_n) else $error("fault not two edges after mismatch");
	a_fault_early: assert property (@(posedge clock) disable iff (!rst_n)
		(s_mismatch and (fault_state == DCRB_PF_IDLE)) |=> parity_fault_n) else $error("fault shown without delay");
	a_fault_width: assert property (@(posedge clock) disable iff (!rst_n)
		s_fault_fall ##0 clk_en |=> !parity_fault_n) else $error("fault pulse shorter than two cycles");
	a_hold_output: assert property (@(posedge clock) disable iff (!rst_n)
		!drive_pop |=> $stable(cmd_addr_outputs_copy_a) && $stable(cmd_addr_outputs_copy_b)) else $error("outputs moved without word");
	a_drive_word: assert property (@(posedge clock) disable iff (!rst_n)
		drive_pop |=> cmd_addr_outputs_copy_a == $past(fifo_data)) else $error("driven word differs");
	// Copies and open-drain enable track each other
	a_copy_pair: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_addr_outputs_copy_a == cmd_addr_outputs_copy_b) else $error("output copies differ");
	a_drive_copy_b: assert property (@(posedge clock) disable iff (!rst_n)
		drive_pop |=> cmd_addr_outputs_copy_b == $past(fifo_data)) else $error("second copy differs");
	a_capture_enters: assert property (@(posedge clock) disable iff (!rst_n)
		(capture && clk_en && !fifo_valid) |=> fifo_valid) else $error("captured word lost");
	a_select_two: assert property (@(posedge clock) disable iff (!rst_n)
		(s_reg.gate_sync && !chip_select_in_2 && clk_en) |-> capture) else $error("select two ignored");
	a_oe_pair: assert property (@(posedge clock) disable iff (!rst_n)
		parity_fault_oe == !parity_fault_n) else $error("fault enable disagrees with level");
	// Fault sequencer steps
	a_state_onehot: assert property (@(posedge clock) disable iff (!rst_n)
		$onehot(fault_state)) else $error("fault state not one-hot");
	a_fault_level: assert property (@(posedge clock) disable iff (!rst_n)
		parity_fault_n == (fault_state != DCRB_PF_LOW)) else $error("fault level disagrees with state");
	a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		(!s_reg.chk_pend && (fault_state == DCRB_PF_IDLE) && clk_en) |=> fault_state == DCRB_PF_IDLE)
		else $error("fault raised without a selected word");
	a_wait_to_low: assert property (@(posedge clock) disable iff (!rst_n)
		(fault_state == DCRB_PF_WAIT && clk_en) |=> fault_state == DCRB_PF_LOW) else $error("wait not followed by low");
	a_fault_release: assert property (@(posedge clock) disable iff (!rst_n)
		s_fault_fall ##0 s_quiet ##1 s_quiet |=> parity_fault_n) else $error("fault pulse longer than two cycles");
	a_fault_restart: assert property (@(posedge clock) disable iff (!rst_n)
		(s_mismatch and (fault_state == DCRB_PF_LOW)) ##1 s_quiet |=> !parity_fault_n) else $error("fault not restarted");
	a_frozen_state: assert property (@(posedge clock) disable iff (!rst_n)
		!clk_en |=> $stable(fault_state) && $stable(parity_fault_n)) else $error("fault moved while frozen");
	// Reset leaves everything idle
	a_ready_reset: assert property (@(posedge clock)
		!rst_n |-> cmd_ready) else $error("buffer not empty in reset");
	a_reset_state: assert property (@(posedge clock)
		!rst_n |-> (fault_state == DCRB_PF_IDLE)) else $error("fault state not idle in reset");
	a_strap_reset: assert property (@(posedge clock)
		!rst_n |-> !strap_ok) else $error("strap flag set in reset");
endmodule : dcrb_buffer

// ---- core/dcrb_defs.svh ----
// Purpose: Shared constants of the command register buffer
// Assumes: Included by bare name from the buffer and FIFO design files
// Notes: Definitions only
`ifndef DCRB_DEFS_SVH
`define DCRB_DEFS_SVH
`define DCRB_CMD_WIDTH 22
`define DCRB_FIFO_DEPTH 8
`define DCRB_FAULT_CYCLES 2
`define DCRB_FAULT_CNT_W 2
`define DCRB_CLOCK_PERIOD_NS 100
`define DCRB_STRAP_LOW_OK 1'h0
`define DCRB_STRAP_HIGH_OK 1'h1
`define DCRB_FAULT_IDLE_N 1'h1
`endif

// ---- core/dcrb_fifo.sv ----
// Purpose: Word FIFO with registered read data and valid/ready on both sides
// Assumes: DEPTH is a power of two of at least two
// Notes: Output register adds one word of storage beyond DEPTH
`timescale 1ns/1ns
`include "dcrb_defs.svh"
module dcrb_fifo #(
	parameter int WIDTH = `DCRB_CMD_WIDTH,
	parameter int DEPTH = `DCRB_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import dcrb_pkg::*;
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
		$error("dcrb_fifo: DEPTH must be a power of two of at least two");
	end
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
		logic ov;
		logic [WIDTH-1:0] od;
	} dcrb_fifo_state_t;
	dcrb_fifo_state_t s_reg;
	dcrb_fifo_state_t s_next;
	logic push;
	logic load;
	logic bypass;
	logic mem_pop;
	logic mem_push;
	assign in_ready = (s_reg.count != (AW+1)'(DEPTH));
	assign out_valid = s_reg.ov;
	assign out_data = s_reg.od;
	always_comb begin
		s_next = s_reg;
		push = in_valid && in_ready && clk_en;
		load = clk_en && (!s_reg.ov || out_ready);
		bypass = 1'b0;
		mem_pop = 1'b0;
		mem_push = 1'b0;
		if (load) begin
			if (s_reg.count != '0) begin
				s_next.od = s_reg.mem[s_reg.rd_ptr];
				s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
				s_next.ov = 1'b1;
				mem_pop = 1'b1;
			end else if (push) begin
				s_next.od = in_data;
				s_next.ov = 1'b1;
				bypass = 1'b1;
			end else begin
				s_next.ov = 1'b0;
			end
		end
		if (push && !bypass) begin
			s_next.mem[s_reg.wr_ptr] = in_data;
			s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
			mem_push = 1'b1;
		end
		s_next.count = s_reg.count + {{AW{1'b0}}, mem_push} - {{AW{1'b0}}, mem_pop};
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	a_no_overflow: assert property (@(posedge clock) disable iff (!rst_n)
		s_reg.count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
	a_full_refuses: assert property (@(posedge clock) disable iff (!rst_n)
		(!in_ready && clk_en && !out_ready) |=> !in_ready) else $error("full fifo freed without pop");
endmodule : dcrb_fifo

// ---- core/dcrb_pkg.sv ----
// Purpose: Types of the command register buffer
// Assumes: Nothing beyond the constants header
// Notes: One-hot codes for the fault sequencer
package dcrb_pkg;
	typedef enum logic [2:0] {
		DCRB_PF_IDLE = 3'h1,
		DCRB_PF_WAIT = 3'h2,
		DCRB_PF_LOW = 3'h4
	} dcrb_pf_state_t;
endpackage : dcrb_pkg
